// ===== sfwc_cfg.svh
// Register offsets, field positions, reset values and limits of the FIFO block
`ifndef SFWC_CFG_SVH
`define SFWC_CFG_SVH

// Register offsets (byte wide registers)
`define SFWC_OFF_CTRL_A   8'h00
`define SFWC_OFF_CTRL_B   8'h01
`define SFWC_OFF_CTRL_C   8'h02
`define SFWC_OFF_EMB_EN   8'h03
`define SFWC_OFF_EMB_INIT 8'h04
`define SFWC_OFF_STAT_A   8'h05
`define SFWC_OFF_STAT_B   8'h06
`define SFWC_OFF_OUT_TAG  8'h07
`define SFWC_OFF_OUT_ZH   8'h0d

// Field positions
`define SFWC_B_WM8        0
`define SFWC_B_RAW_LO     1
`define SFWC_B_RAW_HI     2
`define SFWC_B_RT_EN      3
`define SFWC_B_CAP        7
`define SFWC_B_FEAT_EN    0
`define SFWC_B_REINIT     0
`define SFWC_B_FULL_FLAG  6
`define SFWC_B_WM_FLAG    7

// Reset values
`define SFWC_RST_WM       9'h000
`define SFWC_RST_RAW_RATE 2'h0

// Forced raw word periods in batch events
`define SFWC_RAW_P8       6'h08
`define SFWC_RAW_P16      6'h10
`define SFWC_RAW_P32      6'h20

// Difference limits in LSB
`define SFWC_LIM5         17'sh0_0010
`define SFWC_LIM8         17'sh0_0080

`endif

// ===== sfwc_core.sv
// Sample queue with watermark, size cap and slope compression
//
// Contract
// R1: Nine-bit watermark across two control registers
// R2: Watermark flag when count reaches watermark
// R3: Cap bit makes watermark the queue depth
// R4: Without cap, store until queue full
// R5: Full flag early; watermark flag at full
// R6: Continuous capped mode overwrites oldest word
// R7: Compress only with both enable bits
// R8: Both sensors compressed, levels chosen independently
// R9: Host avoids compression at high rates
// R10: Difference above 128 gives raw word
// R11: Difference 16 to 128 gives pair
// R12: Difference below 16 gives triple
// R13: Five word kinds per sensor
// R14: First event writes raw reference word
// R15: Then triple, pair or oldest raw word
// R16: Middle raw kind only on change, disable
// R17: Words delayed up to two batch periods
// R18: Host rebuilds sample as difference plus previous
// R19: Pair carries six signed bytes, oldest first
// R20: Triple holds three five-bit packed words
// R21: Reinit pulse restarts compression state
// R22: Forced raw word every 8, 16, 32
// R23: Bit 15 of triple words unused
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "sfwc_cfg.svh"

module sfwc_core #(
  parameter int DEPTH = 64
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic [1:0]                sample_valid,
  input  wire sfwc_pkg::sfwc_sample_s [1:0] sample_data,
  input  wire logic                      config_change,
  output logic                           watermark_reached_flag,
  output logic                           queue_full_flag
);
  import sfwc_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [9:0] DEPTH_W = 10'(DEPTH);

  // Whole module state
  typedef struct packed {
    sfwc_word_s [DEPTH-1:0] mem;
    logic [AW-1:0]          wr_ptr;
    logic [AW-1:0]          rd_ptr;
    logic [9:0]             count;
    logic [8:0]             watermark_level;
    logic                   cap_at_watermark;
    logic                   compress_runtime_enable;
    logic [1:0]             forced_raw_rate;
    sfwc_mode_e             mode;
    logic                   compress_feature_enable;
    logic                   wm_flag;
    logic                   full_flag;
    logic [7:0]             rdata;
    sfwc_chan_s [1:0]       ch;
  } sfwc_state_s;

  sfwc_state_s s;
  sfwc_state_s next_s;

  // Signed 17-bit difference of two 16-bit samples
  function automatic logic signed [16:0] dif(input logic [15:0] a,
                                             input logic [15:0] b);
    dif = $signed({a[15], a}) - $signed({b[15], b});
  endfunction

  // All three axis differences inside +-lim
  function automatic logic fits(input sfwc_sample_s a,
                                input sfwc_sample_s b,
                                input logic signed [16:0] lim);
    logic signed [16:0] dx;
    logic signed [16:0] dy;
    logic signed [16:0] dz;
    dx = dif(a.x, b.x);
    dy = dif(a.y, b.y);
    dz = dif(a.z, b.z);
    fits = (dx >= -lim) && (dx < lim) && (dy >= -lim) && (dy < lim)
           && (dz >= -lim) && (dz < lim);
  endfunction

  // Three five-bit differences, top bit left clear
  function automatic logic [15:0] pack5(input sfwc_sample_s a,
                                        input sfwc_sample_s b);
    logic signed [16:0] dx;
    logic signed [16:0] dy;
    logic signed [16:0] dz;
    dx = dif(a.x, b.x);
    dy = dif(a.y, b.y);
    dz = dif(a.z, b.z);
    pack5 = {1'b0, dz[4:0], dy[4:0], dx[4:0]}; // [R20] [R23]
  endfunction

  // Three byte differences, x first
  function automatic logic [23:0] pack8(input sfwc_sample_s a,
                                        input sfwc_sample_s b);
    logic signed [16:0] dx;
    logic signed [16:0] dy;
    logic signed [16:0] dz;
    dx = dif(a.x, b.x);
    dy = dif(a.y, b.y);
    dz = dif(a.z, b.z);
    pack8 = {dz[7:0], dy[7:0], dx[7:0]};
  endfunction

  // Tag byte from sensor and kind
  function automatic logic [7:0] mk_tag(input logic sens,
                                        input sfwc_kind_e kind);
    mk_tag = {4'h0, sens, kind}; // [R13]
  endfunction

  // Append a word to a sensor's outgoing queue
  function automatic sfwc_chan_s enq(input sfwc_chan_s c,
                                     input sfwc_word_s w);
    enq = c;
    if (c.qcnt != 2'h3)
    begin
      enq.q[c.qcnt] = w;
      enq.qcnt      = c.qcnt + 2'h1;
    end
  endfunction

  // Slope classes and packed words per sensor
  logic [1:0]       small5;
  logic [1:0]       small8;
  sfwc_word_s [1:0] triple_w;
  sfwc_word_s [1:0] pair_w;

  for (genvar g = 0; g < 2; g++)
  begin : g_sens
    sfwc_sample_s rf;
    sfwc_sample_s p0;
    sfwc_sample_s p1;
    sfwc_sample_s cu;
    assign rf = s.ch[g].ref_smp;
    assign p0 = s.ch[g].pend[0];
    assign p1 = s.ch[g].pend[1];
    assign cu = sample_data[g];
    // Window of i-2, i-1, i against last stored sample
    assign small5[g] = fits(p0, rf, `SFWC_LIM5) && fits(p1, p0, `SFWC_LIM5)
                       && fits(cu, p1, `SFWC_LIM5);          // [R12]
    assign small8[g] = fits(p0, rf, `SFWC_LIM8)
                       && fits(p1, p0, `SFWC_LIM8);          // [R11]
    assign triple_w[g].tag  = mk_tag(1'(g), KIND_TRIPLE);
    assign triple_w[g].data = {pack5(cu, p1), pack5(p1, p0),
                               pack5(p0, rf)};              // [R20]
    assign pair_w[g].tag    = mk_tag(1'(g), KIND_PAIR);
    assign pair_w[g].data   = {pack8(p1, p0), pack8(p0, rf)}; // [R19]
  end

  // Next state: drain, compress, queue, registers
  always_comb
  begin
    sfwc_chan_s   c;
    sfwc_word_s   pw;
    sfwc_word_s   ow;
    logic         push;
    logic         act;
    logic         force_raw;
    logic [5:0]   per;
    logic [9:0]   eff;
    c         = '0;
    pw        = '0;
    ow        = '0;
    push      = 1'b0;
    act       = 1'b0;
    force_raw = 1'b0;
    per       = '0;
    eff       = '0;
    next_s    = s;

    // One word per cycle into the queue, accel first
    for (int i = 0; i < 2; i++)
    begin
      if (!push && next_s.ch[i].qcnt != 2'h0)
      begin
        push = 1'b1;
        pw   = next_s.ch[i].q[0];
        next_s.ch[i].q    = {sfwc_word_s'('0), next_s.ch[i].q[2:1]};
        next_s.ch[i].qcnt = next_s.ch[i].qcnt - 2'h1;
      end
    end

    act = s.compress_feature_enable && s.compress_runtime_enable; // [R7]
    case (s.forced_raw_rate)
      2'h1:    per = `SFWC_RAW_P8;
      2'h2:    per = `SFWC_RAW_P16;
      2'h3:    per = `SFWC_RAW_P32;
      default: per = '0;
    endcase

    // Each sensor decides its own level [R8]
    for (int i = 0; i < 2; i++)
    begin
      c = next_s.ch[i];
      if (sample_valid[i] && s.mode != MODE_BYPASS)
      begin
        if (!act || c.flush || c.phase == PH_REF)
        begin
          // Flush pending samples, then current as raw
          if (c.pcnt == 2'h2)
          begin
            ow = '{tag: mk_tag(1'(i), KIND_RAW_T2), data: c.pend[0]};
            c  = enq(c, ow);
          end
          if (c.pcnt != 2'h0)
          begin
            ow = '{tag: mk_tag(1'(i), KIND_RAW_T1),
                   data: c.pend[c.pcnt - 2'h1]};             // [R16]
            c  = enq(c, ow);
          end
          ow        = '{tag: mk_tag(1'(i), KIND_RAW), data: sample_data[i]};
          c         = enq(c, ow);                            // [R14]
          c.ref_smp = sample_data[i];
          c.pcnt    = 2'h0;
          c.raw_cnt = '0;
          c.flush   = 1'b0;
          c.phase   = act ? PH_RUN : PH_REF;
        end
        else if (c.pcnt != 2'h2)
        begin
          // Hold sample until the window is full
          c.pend[c.pcnt[0]] = sample_data[i];                // [R17]
          c.pcnt            = c.pcnt + 2'h1;
          if (c.raw_cnt != 6'h3f)
            c.raw_cnt = c.raw_cnt + 6'h01;
        end
        else
        begin
          force_raw = (per != '0) && (c.raw_cnt + 6'h01 >= per); // [R22]
          if (!force_raw && small5[i])
          begin
            c         = enq(c, triple_w[i]);                 // [R12] [R15]
            c.ref_smp = sample_data[i];
            c.pcnt    = 2'h0;
            c.raw_cnt = c.raw_cnt + 6'h01;
          end
          else if (!force_raw && small8[i])
          begin
            c         = enq(c, pair_w[i]);                   // [R11] [R15]
            c.ref_smp = c.pend[1];
            c.pend[0] = sample_data[i];
            c.pcnt    = 2'h1;
            c.raw_cnt = c.raw_cnt + 6'h01;
          end
          else
          begin
            // Slope too steep or raw word due
            ow = '{tag: mk_tag(1'(i), KIND_RAW_T2), data: c.pend[0]};
            c         = enq(c, ow);                          // [R10] [R15]
            c.ref_smp = c.pend[0];
            c.pend[0] = c.pend[1];
            c.pend[1] = sample_data[i];
            c.raw_cnt = '0;
          end
        end
      end
      // Change request wins over the flush taken above
      if (config_change)
        c.flush = 1'b1;                                      // [R16]
      next_s.ch[i] = c;
    end

    // Register writes
    next_s.rdata = '0;
    if (reg_wr)
    begin
      case (reg_addr)
        `SFWC_OFF_CTRL_A:
          next_s.watermark_level[7:0] = reg_wdata;           // [R1]
        `SFWC_OFF_CTRL_B:
        begin
          next_s.watermark_level[8]      = reg_wdata[`SFWC_B_WM8]; // [R1]
          next_s.forced_raw_rate         =
            reg_wdata[`SFWC_B_RAW_HI:`SFWC_B_RAW_LO];
          next_s.compress_runtime_enable = reg_wdata[`SFWC_B_RT_EN];
          next_s.cap_at_watermark        = reg_wdata[`SFWC_B_CAP];
          if (s.compress_runtime_enable && !reg_wdata[`SFWC_B_RT_EN])
          begin
            next_s.ch[0].flush = 1'b1;                       // [R16]
            next_s.ch[1].flush = 1'b1;
          end
        end
        `SFWC_OFF_CTRL_C:
          next_s.mode = sfwc_mode_e'(reg_wdata[1:0]);
        `SFWC_OFF_EMB_EN:
          next_s.compress_feature_enable = reg_wdata[`SFWC_B_FEAT_EN];
        `SFWC_OFF_EMB_INIT:
        begin
          // Self-clearing restart of both compressors
          if (reg_wdata[`SFWC_B_REINIT])
          begin
            next_s.ch[0] = '{phase: PH_REF, default: '0};    // [R21]
            next_s.ch[1] = '{phase: PH_REF, default: '0};
          end
        end
        default:
          next_s.rdata = '0;
      endcase
    end

    // Register reads, answered in the next cycle
    if (reg_rd)
    begin
      ow = s.mem[s.rd_ptr];
      case (reg_addr)
        `SFWC_OFF_CTRL_A:  next_s.rdata = s.watermark_level[7:0];
        `SFWC_OFF_CTRL_B:  next_s.rdata = {s.cap_at_watermark, 3'h0,
                                           s.compress_runtime_enable,
                                           s.forced_raw_rate,
                                           s.watermark_level[8]};
        `SFWC_OFF_CTRL_C:  next_s.rdata = {6'h00, s.mode};
        `SFWC_OFF_EMB_EN:  next_s.rdata = {7'h00, s.compress_feature_enable};
        `SFWC_OFF_STAT_A:  next_s.rdata = s.count[7:0];
        `SFWC_OFF_STAT_B:  next_s.rdata = {s.wm_flag, s.full_flag, 4'h0,
                                           s.count[9:8]};
        `SFWC_OFF_OUT_TAG: next_s.rdata = (s.count != '0) ? ow.tag : 8'h00;
        default:
        begin
          if (reg_addr > `SFWC_OFF_OUT_TAG && reg_addr <= `SFWC_OFF_OUT_ZH
              && s.count != '0)
            next_s.rdata = ow.data[8 * (reg_addr - `SFWC_OFF_OUT_TAG - 8'h01)
                                   +: 8];
          else
            next_s.rdata = '0;
        end
      endcase
      // Last byte of a word releases it
      if (reg_addr == `SFWC_OFF_OUT_ZH && s.count != '0)
      begin
        next_s.rd_ptr = (s.rd_ptr == AW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
        next_s.count  = s.count - 10'h001;
      end
    end

    // Effective depth: watermark when capped
    if (s.cap_at_watermark && s.watermark_level != '0
        && {1'b0, s.watermark_level} < DEPTH_W)
      eff = {1'b0, s.watermark_level};                       // [R3]
    else
      eff = DEPTH_W;                                         // [R4]

    // Store the drained word
    if (push && s.mode != MODE_BYPASS)
    begin
      if (next_s.count < eff)
      begin
        next_s.mem[next_s.wr_ptr] = pw;
        next_s.wr_ptr = (next_s.wr_ptr == AW'(DEPTH - 1)) ? '0
                        : next_s.wr_ptr + 1'b1;
        next_s.count  = next_s.count + 10'h001;
      end
      else if (s.mode == MODE_CONT)
      begin
        // Oldest word lost so the newest always lands
        next_s.mem[next_s.wr_ptr] = pw;                      // [R6]
        next_s.wr_ptr = (next_s.wr_ptr == AW'(DEPTH - 1)) ? '0
                        : next_s.wr_ptr + 1'b1;
        next_s.rd_ptr = (next_s.rd_ptr == AW'(DEPTH - 1)) ? '0
                        : next_s.rd_ptr + 1'b1;
      end
    end

    // Bypass empties the queue
    if (next_s.mode == MODE_BYPASS)
    begin
      next_s.count  = '0;
      next_s.wr_ptr = '0;
      next_s.rd_ptr = '0;
    end

    // Status flags follow the stored count
    next_s.wm_flag   = next_s.count >= {1'b0, next_s.watermark_level}; // [R2]
    next_s.full_flag = (next_s.count + 10'h001) >= eff;      // [R5]
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s                 <= '0;
      s.watermark_level <= `SFWC_RST_WM;
      s.forced_raw_rate <= `SFWC_RST_RAW_RATE;
      s.mode            <= MODE_BYPASS;
      s.ch[0].phase     <= PH_REF;
      s.ch[1].phase     <= PH_REF;
      s.wm_flag         <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata              = s.rdata;
  assign watermark_reached_flag = s.wm_flag;
  assign queue_full_flag        = s.full_flag;

endmodule

// ===== sfwc_core_sva.sv
// Assertions on the FIFO core register port and flags
`timescale 1ns/100ps
module sfwc_core_sva #(
  parameter int DEPTH = 64
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] sample_valid,
  input wire logic       config_change,
  input wire logic       watermark_reached_flag,
  input wire logic       queue_full_flag
);
  logic [8:0] wm;
  logic       cap;
  logic [2:0] quiet;
  logic       act;
  logic       ok;
  logic       rd_void;

  // Anything that may move the count restarts the settle count
  assign act = (sample_valid != 2'h0) || reg_wr || config_change ||
               (reg_rd && reg_addr == 8'h0D);
  assign ok = quiet == 3'h7; // Six words may trail one event
  assign rd_void = reg_rd && (reg_addr == 8'h04 || reg_addr > 8'h0D);

  // Shadow of level and cap; flags lag words, so judge only when settled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wm    <= 9'h000;
      cap   <= 1'b0;
      quiet <= 3'h0;
    end
    else
    begin
      quiet <= act ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      if (reg_wr && reg_addr == 8'h00)
        wm[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == 8'h01)
      begin
        wm[8] <= reg_wdata[0];
        cap   <= reg_wdata[7];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_void_zero: assert property (
    rd_void |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_tag_form: assert property (
    reg_rd && reg_addr == 8'h07 |=> reg_rdata[7:4] == 4'h0 &&
    reg_rdata[2:0] <= 3'h4) else $error("tag byte malformed");
  a_status_flags: assert property (
    reg_rd && reg_addr == 8'h06 && ok |=> reg_rdata[7:6] ==
    $past({watermark_reached_flag, queue_full_flag}))
    else $error("status bits differ from flags");
  a_wm_zero: assert property (
    wm == 9'h000 && ok |-> watermark_reached_flag)
    else $error("zero level without flag");
  a_cap_full: assert property (
    cap && wm != 9'h000 && wm < DEPTH && ok && watermark_reached_flag
    |-> queue_full_flag) else $error("capped level reached, not full");
  a_flags_quiet: assert property (
    ok |-> $stable({watermark_reached_flag, queue_full_flag}))
    else $error("flag moved without cause");
  a_bypass_empty: assert property (
    reg_wr && reg_addr == 8'h02 && reg_wdata[1:0] == 2'h0 &&
    !(cap && wm == 9'h001) |-> ##[1:4] !queue_full_flag)
    else $error("full after queue cleared");

  c_triple: cover property (reg_rd && reg_addr == 8'h07 ##1
    reg_rdata[2:0] == 3'h4);
  c_full: cover property ($rose(queue_full_flag));
  c_wm_fall: cover property ($fell(watermark_reached_flag));
endmodule

bind sfwc_core sfwc_core_sva #(.DEPTH(DEPTH)) u_sfwc_core_sva (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .sample_valid, .config_change, .watermark_reached_flag, .queue_full_flag
);

// ===== sfwc_host.sv
// Host model: register port master and queue word decoder
`timescale 1ns/100ps
module sfwc_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  import sfwc_pkg::*;
  sfwc_sample_s last [2];

  // Bus idles with both strobes low from time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One write cycle; released lines flip so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
    reg_addr  <= ~a;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask

  function automatic sfwc_sample_s step(input sfwc_sample_s p,
    input logic [15:0] dx, input logic [15:0] dy, input logic [15:0] dz);
    return '{z: p.z + dz, y: p.y + dy, x: p.x + dx};
  endfunction

  // Whole word read; differences applied oldest slot first
  task automatic rd_word(output logic [7:0] t, output logic [47:0] w);
    logic [7:0]  b;
    logic [23:0] p;
    logic [14:0] f;
    int          s;
    rd(8'h07, t);
    for (int i = 0; i < 6; i++)
    begin
      rd(8'h08 + 8'(i), b);
      w[8*i +: 8] = b;
    end
    s = int'(t[3]);
    for (int k = 0; k < 3; k++)
    begin
      p = (k < 2) ? w[24*k +: 24] : 24'h00_0000;
      f = w[16*k +: 15]; // Top bit of each word ignored
      if (t[2:0] == 3'h3 && k < 2)
        last[s] = step(last[s], {{8{p[7]}}, p[7:0]},
                       {{8{p[15]}}, p[15:8]}, {{8{p[23]}}, p[23:16]});
      else if (t[2:0] == 3'h4)
        last[s] = step(last[s], {{11{f[4]}}, f[4:0]},
                       {{11{f[9]}}, f[9:5]}, {{11{f[14]}}, f[14:10]});
    end
    if (t[2:0] < 3'h3)
      last[s] = w;
  endtask
endmodule

// ===== sfwc_pkg.sv
// Types shared by the FIFO watermark and compression block
package sfwc_pkg;

  // One three-axis sample
  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } sfwc_sample_s;

  // One stored queue word: tag byte plus six data bytes, X_L lowest
  typedef struct packed {
    logic [7:0]  tag;
    logic [47:0] data;
  } sfwc_word_s;

  // Word kinds carried in the tag
  typedef enum logic [2:0] {
    KIND_RAW    = 3'h0,
    KIND_RAW_T1 = 3'h1,
    KIND_RAW_T2 = 3'h2,
    KIND_PAIR   = 3'h3,
    KIND_TRIPLE = 3'h4
  } sfwc_kind_e;

  // Queue modes
  typedef enum logic [1:0] {
    MODE_BYPASS = 2'h0,
    MODE_STOP   = 2'h1,
    MODE_CONT   = 2'h2
  } sfwc_mode_e;

  // Compressor phase, one-hot
  typedef enum logic [1:0] {
    PH_REF = 2'b01,
    PH_RUN = 2'b10
  } sfwc_phase_e;

  // Per-sensor compressor state
  typedef struct packed {
    sfwc_phase_e        phase;
    sfwc_sample_s       ref_smp;
    sfwc_sample_s [1:0] pend;
    logic [1:0]         pcnt;
    logic [5:0]         raw_cnt;
    logic               flush;
    logic [1:0]         qcnt;
    sfwc_word_s [2:0]   q;
  } sfwc_chan_s;

endpackage

// ===== testbench.sv
// Self-checking bench for the FIFO watermark and compression core
`timescale 1ns/100ps
module testbench;
  import sfwc_pkg::*;
  logic               clk;
  logic               rst_n;
  logic [7:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_rdata;
  logic [1:0]         sample_valid;
  sfwc_sample_s [1:0] sample_data;
  logic               config_change;
  logic               watermark_reached_flag;
  logic               queue_full_flag;
  int                 bad_count;
  int                 tests_run;
  logic [15:0]        dd [2:7][0:2];
  sfwc_sample_s       acc [1:7];

  // Small depth keeps fill scenarios short
  sfwc_core #(.DEPTH(8)) u_sfwc_core (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sample_valid, .sample_data, .config_change, .watermark_reached_flag,
    .queue_full_flag
  );
  sfwc_host u_sfwc_host (
    .clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chkw(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chkw({40'h0, got}, {40'h0, exp});
  endtask

  task automatic expr(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_sfwc_host.rd(a, d);
    chk8(d, e);
  endtask

  task automatic expf(input logic w, input logic f);
    chk8({6'h0, watermark_reached_flag, queue_full_flag}, {6'h0, w, f});
  endtask

  task automatic expw(input logic [7:0] t, input logic [47:0] w);
    logic [7:0]  gt;
    logic [47:0] gw;
    u_sfwc_host.rd_word(gt, gw);
    chk8(gt, t);
    chkw(gw, w);
  endtask

  // One batch event, then enough idle cycles for the word queue to drain
  task automatic ev(input logic [1:0] v, input sfwc_sample_s a,
                    input sfwc_sample_s g);
    @(posedge clk);
    sample_valid   <= v;
    sample_data[0] <= a;
    sample_data[1] <= g;
    @(posedge clk);
    sample_valid   <= 2'h0;
    repeat (10) @(posedge clk);
  endtask

  // Steps of 200 in x always exceed the pair range
  function automatic sfwc_sample_s gsm(input logic [15:0] k);
    return '{z: 16'h3000 + k, y: 16'h2000 + k, x: 16'h1000 + 16'h00C8 * k};
  endfunction

  function automatic logic [15:0] pk5(input int i);
    return {1'b0, dd[i][2][4:0], dd[i][1][4:0], dd[i][0][4:0]};
  endfunction

  function automatic logic [23:0] by8(input int i);
    return {dd[i][2][7:0], dd[i][1][7:0], dd[i][0][7:0]};
  endfunction

  task automatic t_reset();
    for (int a = 0; a < 5; a++)
      expr(a[7:0], 8'h00);
    expr(8'h06, 8'h80);
    expr(8'h20, 8'h00);
    expf(1'b1, 1'b0);
  endtask

  task automatic t_watermark();
    int n;
    u_sfwc_host.wr(8'h02, 8'h01);
    u_sfwc_host.wr(8'h00, 8'h03);
    for (int i = 1; i <= 9; i++)
    begin
      ev(2'h1, gsm(i[15:0]), gsm(16'h0000));
      n = (i > 8) ? 8 : i;
      expr(8'h05, n[7:0]);
      expf(n >= 3, n >= 7);
    end
    u_sfwc_host.wr(8'h01, 8'h01);
    expr(8'h06, 8'h40);
    u_sfwc_host.wr(8'h01, 8'h00);
    expw(8'h00, gsm(16'h0001));
  endtask

  task automatic t_cap();
    int n;
    u_sfwc_host.wr(8'h02, 8'h00);
    u_sfwc_host.wr(8'h02, 8'h02);
    u_sfwc_host.wr(8'h00, 8'h04);
    u_sfwc_host.wr(8'h01, 8'h80);
    for (int i = 1; i <= 6; i++)
    begin
      ev(2'h1, gsm(i[15:0]), gsm(16'h0000));
      n = (i > 4) ? 4 : i;
      expr(8'h05, n[7:0]);
      expf(n >= 4, n >= 3);
    end
    expw(8'h00, gsm(16'h0003));
    u_sfwc_host.wr(8'h01, 8'h00);
  endtask

  // Both streams first, then accel alone; rates are far below the limits
  task automatic t_compress();
    u_sfwc_host.wr(8'h02, 8'h00);
    u_sfwc_host.wr(8'h04, 8'h01);
    u_sfwc_host.wr(8'h03, 8'h01);
    u_sfwc_host.wr(8'h01, 8'h08);
    u_sfwc_host.wr(8'h02, 8'h01);
    for (int i = 1; i <= 7; i++)
    begin
      ev(i < 5 ? 2'h3 : 2'h1, acc[i], gsm(i[15:0]));
      if (i == 3)
        expr(8'h05, 8'h02);
    end
    expr(8'h05, 8'h05);
    expw(8'h00, acc[1]);
    expw(8'h08, gsm(16'h0001));
    expw(8'h04, {pk5(4), pk5(3), pk5(2)});
    expw(8'h0A, gsm(16'h0002));
    expw(8'h03, {by8(6), by8(5)});
    chkw(u_sfwc_host.last[0], acc[6]);
  endtask

  task automatic t_flush();
    u_sfwc_host.wr(8'h02, 8'h00);
    u_sfwc_host.wr(8'h04, 8'h01);
    u_sfwc_host.wr(8'h02, 8'h01);
    for (int i = 1; i <= 4; i++)
    begin
      if (i == 4)
      begin
        @(posedge clk);
        config_change <= 1'b1;
        @(posedge clk);
        config_change <= 1'b0;
      end
      ev(2'h1, acc[i], gsm(16'h0000));
    end
    expw(8'h00, acc[1]);
    expw(8'h02, acc[2]);
    expw(8'h01, acc[3]);
    expw(8'h00, acc[4]);
  endtask

  // Disable flushes the window; rate code forces a raw word
  task automatic t_rt_raw();
    ev(2'h1, acc[5], acc[1]);
    ev(2'h1, acc[6], acc[1]);
    u_sfwc_host.wr(8'h01, 8'h00);
    ev(2'h1, acc[7], acc[1]);
    expw(8'h02, acc[5]);
    expw(8'h01, acc[6]);
    expw(8'h00, acc[7]);
    u_sfwc_host.wr(8'h01, 8'h0A);
    for (int i = 0; i < 10; i++)
      ev(2'h1, acc[7], acc[1]);
    expr(8'h05, 8'h04);
    expw(8'h00, acc[7]);
    expw(8'h04, 48'h0);
    expw(8'h04, 48'h0);
    expw(8'h02, acc[7]);
  endtask

  // Cuts a hung run short
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    bad_count     = 0;
    tests_run     = 0;
    rst_n         = 1'b0;
    sample_valid  = 2'h0;
    sample_data   = '0;
    config_change = 1'b0;
    dd[2] = '{16'h0001, 16'hFFFE, 16'h0003};
    dd[3] = '{16'h0004, 16'h0005, 16'hFFFA};
    dd[4] = '{16'hFFF9, 16'h0008, 16'h000F};
    dd[5] = '{16'h0014, 16'hFFE2, 16'h0064};
    dd[6] = '{16'hFFCE, 16'h003C, 16'hFF80};
    dd[7] = '{16'h0000, 16'h0000, 16'h0000};
    acc[1] = '{z: 16'h0300, y: 16'h0200, x: 16'h0100};
    for (int i = 2; i <= 7; i++)
      acc[i] = '{z: acc[i-1].z + dd[i][2], y: acc[i-1].y + dd[i][1],
                 x: acc[i-1].x + dd[i][0]};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_watermark();
    t_cap();
    t_compress();
    t_flush();
    t_rt_raw();
    give_verdict();
  end
endmodule
